// File: hdl/sci_rx_defines.svh
`ifndef SCI_RX_DEFINES_SVH
`define SCI_RX_DEFINES_SVH

`define ADDR_CTRL 4'h0
`define ADDR_IRQ_EN 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_DATA 4'h3

`define CTRL_STANDBY 0
`define CTRL_EXIT_SEL 1
`define CTRL_QUIET_SEL 2
`define CTRL_CHAR9 3
`define CTRL_PAR_EN 4
`define CTRL_PAR_ODD 5
`define CTRL_RESET 6'h00

`define FLG_FULL 0
`define FLG_QUIET 1
`define FLG_OVR 2
`define FLG_NOISE 3
`define FLG_FRAME 4
`define FLG_PAR 5
`define FLAGS_RESET 6'h00
`define IRQ_EN_RESET 6'h00
`define ST_BUSY 6

`define RT_FIRST 5'h01
`define RT_AFTER_EDGE 5'h02
`define RT_VER_A 5'h03
`define RT_LATE 5'h04
`define RT_VER_B 5'h05
`define RT_VER_C 5'h07
`define RT_SMP_A 5'h08
`define RT_SMP_B 5'h09
`define RT_SMP_C 5'h0A
`define RT_EARLY 5'h0B
`define RT_LAST 5'h10

`define BITS_8 4'h8
`define BITS_9 4'h9
`define QUIET_TICKS_8 8'hA0
`define QUIET_TICKS_9 8'hB0
`define TICK_DIV_DEFAULT 16'h0015

`endif

// File: hdl/sci_rx_pkg.sv
package sci_rx_pkg;
    typedef enum logic [1:0] {
        st_hunt = 2'b00,
        st_start = 2'b01,
        st_data = 2'b10,
        st_stop = 2'b11
    } rx_state_type;
endpackage

// File: hdl/rx_line_if.sv
`timescale 1ns/1ps
interface rx_line_if;
    logic tick;
    logic level;
    modport tick_src (output tick);
    modport line_src (output level);
    modport sink (input tick, input level);
endinterface

// File: hdl/oversample_tick_gen.sv
`timescale 1ns/1ps
`include "sci_rx_defines.svh"
module oversample_tick_gen #(
    parameter logic [15:0] TICK_DIV = `TICK_DIV_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst,
    rx_line_if.tick_src line
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 16'h0001;
        tick_nxt = 1'b0;
        if (cnt_r == TICK_DIV - 16'h0001) begin
            cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign line.tick = tick_r;
endmodule

// File: hdl/rx_pin_sync.sv
`timescale 1ns/1ps
module rx_pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    rx_line_if.line_src line
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic level_nxt;

    // A change counts only once the second and third stages agree
    always_comb begin
        level_nxt = (s2_r == s3_r) ? s3_r : level_r;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level_r <= 1'b1;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign line.level = level_r;
endmodule

// File: hdl/sci_receiver.sv
`timescale 1ns/1ps
`include "sci_rx_defines.svh"
// Overview of operation
// - Start-bit RT8-10 samples never cancel a start; any 1 sets noise.
// - Stop bit sampled at RT8-10; majority 0 framing error, disagreement noise.
// - No 1 at stop position, break included, sets framing error.
// - Framing error flag rises in the same cycle as receive-full.
// - Valid falling edges inside a character realign the oversample counter.
// - Sixteen ticks per bit; stop sampling ends at tick 10 of stop bit.
// - Standby request suppresses receiver interrupt requests.
// - Address-mark mode: MSB-one character wakes receiver and sets receive-full.
// - Idle-line mode: idle character wakes receiver, sets no quiet or full flag.
// - Quiet count start selectable: after start bit or after stop bit.
// - Idle-line mode may wake at once if line already idle.
// - Character transfer sets receive-full; enabled flag raises receiver interrupt.
// - Ten or eleven consecutive ones set quiet flag; enable gates interrupt.
// - Overrun keeps old data, drops new, sets overrun flag; enable gates error irq.
// - Noise in any bit sets noise flag; enable gates error interrupt.
// - Enabled framing error raises error interrupt.
// - Parity failure sets parity flag; enable gates error interrupt.
// - Exit select 1 address mark, 0 idle line; reset gives idle line.
// - Quiet select 1 counts after stop, 0 after start; reset clears.
// - Character length select 0 eight bits, 1 nine bits.
module sci_receiver
    import sci_rx_pkg::*;
#(
    parameter logic [15:0] TICK_DIV = `TICK_DIV_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_input_pin,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic rx_irq,
    output logic err_irq
);
    rx_line_if line_bus ();

    rx_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(serial_input_pin),
        .line(line_bus.line_src)
    );

    oversample_tick_gen #(.TICK_DIV(TICK_DIV)) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .line(line_bus.tick_src)
    );

    logic tick;
    logic lvl;
    assign tick = line_bus.tick;
    assign lvl = line_bus.level;

    // Frame state
    rx_state_type state_r, state_nxt;
    logic [4:0] rt_r, rt_nxt;
    logic [3:0] bit_idx_r, bit_idx_nxt;
    logic [8:0] shift_r, shift_nxt;
    logic [2:0] hunt_r, hunt_nxt;
    logic [1:0] samp_r, samp_nxt;
    logic last_bit_r, last_bit_nxt;
    logic noise_r, noise_nxt;
    logic [7:0] quiet_cnt_r, quiet_cnt_nxt;
    logic done_c;
    logic maj_c;
    logic dis_c;
    logic quiet_hit_c;

    // Registers
    logic [5:0] ctrl_r, ctrl_nxt;
    logic [5:0] irq_en_r, irq_en_nxt;
    logic [5:0] flags_r, flags_nxt;
    logic [8:0] data_buf_r, data_buf_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic rx_irq_r, rx_irq_nxt;
    logic err_irq_r, err_irq_nxt;

    logic char9;
    logic [3:0] nbits;
    logic [7:0] quiet_max;
    logic quiet_allow;
    logic [2:0] trio;
    logic parity_bad;

    assign char9 = ctrl_r[`CTRL_CHAR9];
    assign nbits = char9 ? `BITS_9 : `BITS_8;
    assign quiet_max = char9 ? `QUIET_TICKS_9 : `QUIET_TICKS_8;
    assign trio = {samp_r, lvl};
    assign maj_c = (trio[0] & trio[1]) | (trio[0] & trio[2]) | (trio[1] & trio[2]);
    assign dis_c = (trio != 3'b000) && (trio != 3'b111);
    // Counting from the start bit can mistake trailing data ones for idle
    assign quiet_allow = (state_r == st_hunt) ||
        (!ctrl_r[`CTRL_QUIET_SEL] && (state_r != st_start));
    assign parity_bad = ctrl_r[`CTRL_PAR_EN] &&
        (((char9 ? ^shift_r : ^shift_r[8:1])) != ctrl_r[`CTRL_PAR_ODD]);

    always_comb begin
        state_nxt = state_r;
        rt_nxt = rt_r;
        bit_idx_nxt = bit_idx_r;
        shift_nxt = shift_r;
        hunt_nxt = hunt_r;
        samp_nxt = samp_r;
        last_bit_nxt = last_bit_r;
        noise_nxt = noise_r;
        quiet_cnt_nxt = quiet_cnt_r;
        done_c = 1'b0;
        quiet_hit_c = 1'b0;
        if (tick) begin
            rt_nxt = rt_r + `RT_FIRST;
            hunt_nxt = {hunt_r[1:0], lvl};
            if (rt_r == `RT_VER_A || rt_r == `RT_VER_B || rt_r == `RT_SMP_A || rt_r == `RT_SMP_B) begin
                samp_nxt = {samp_r[0], lvl};
            end
            if (lvl && quiet_allow) begin
                if (quiet_cnt_r < quiet_max) begin
                    quiet_cnt_nxt = quiet_cnt_r + 8'h01;
                    quiet_hit_c = (quiet_cnt_r == quiet_max - 8'h01);
                end
            end else begin
                quiet_cnt_nxt = 8'h00;
            end
            case (state_r)
                st_hunt: begin
                    rt_nxt = `RT_FIRST;
                    if (hunt_r == 3'b111 && !lvl) begin
                        state_nxt = st_start;
                        rt_nxt = `RT_AFTER_EDGE;
                        noise_nxt = 1'b0;
                        bit_idx_nxt = 4'h0;
                        shift_nxt = 9'h000;
                    end
                end
                st_start: begin
                    if (rt_r == `RT_VER_C && (trio[0] + trio[1] + trio[2]) >= 2'd2) begin
                        state_nxt = st_hunt;
                        hunt_nxt = 3'b000;
                    end else if (rt_r == `RT_VER_C) begin
                        noise_nxt = dis_c;
                    end
                    // Late samples only add noise, never abort the start
                    if (rt_r == `RT_SMP_C && (trio != 3'b000)) begin
                        noise_nxt = 1'b1;
                    end
                    if (rt_r == `RT_LAST) begin
                        state_nxt = st_data;
                        rt_nxt = `RT_FIRST;
                        last_bit_nxt = 1'b0;
                    end
                end
                st_data: begin
                    if (rt_r == `RT_SMP_C) begin
                        shift_nxt = {maj_c, shift_r[8:1]};
                        last_bit_nxt = maj_c;
                        noise_nxt = noise_r | dis_c;
                    end
                    if (last_bit_r && hunt_r[0] && !lvl && (rt_r >= `RT_EARLY || rt_r <= `RT_LATE)) begin
                        rt_nxt = `RT_AFTER_EDGE;
                        last_bit_nxt = 1'b0;
                    end
                    if (rt_r == `RT_LAST || (rt_nxt == `RT_AFTER_EDGE && rt_r >= `RT_EARLY)) begin
                        // An edge seen on tick 16 is RT1 of the next bit, so keep its realignment
                        if (rt_nxt != `RT_AFTER_EDGE) begin
                            rt_nxt = `RT_FIRST;
                        end
                        if (bit_idx_r == nbits - 4'h1) begin
                            state_nxt = st_stop;
                        end else begin
                            bit_idx_nxt = bit_idx_r + 4'h1;
                        end
                    end
                end
                st_stop: begin
                    if (rt_r == `RT_SMP_C) begin
                        done_c = 1'b1;
                        state_nxt = st_hunt;
                        rt_nxt = `RT_FIRST;
                        hunt_nxt = maj_c ? 3'b111 : 3'b000;
                    end
                end
                default: begin
                    state_nxt = st_hunt;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= st_hunt;
            rt_r <= `RT_FIRST;
            bit_idx_r <= 4'h0;
            shift_r <= 9'h000;
            hunt_r <= 3'b000;
            samp_r <= 2'b00;
            last_bit_r <= 1'b0;
            noise_r <= 1'b0;
            quiet_cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            rt_r <= rt_nxt;
            bit_idx_r <= bit_idx_nxt;
            shift_r <= shift_nxt;
            hunt_r <= hunt_nxt;
            samp_r <= samp_nxt;
            last_bit_r <= last_bit_nxt;
            noise_r <= noise_nxt;
            quiet_cnt_r <= quiet_cnt_nxt;
        end
    end

    // Register file; hardware sets beat software clears in the same cycle
    logic standby;
    logic idle_wake;
    assign standby = ctrl_r[`CTRL_STANDBY];
    assign idle_wake = standby && !ctrl_r[`CTRL_EXIT_SEL] && (quiet_hit_c || quiet_cnt_r == quiet_max);

    always_comb begin
        ctrl_nxt = ctrl_r;
        irq_en_nxt = irq_en_r;
        flags_nxt = flags_r;
        data_buf_nxt = data_buf_r;
        rdata_nxt = 16'h0000;
        if (reg_wr && reg_addr == `ADDR_STATUS) begin
            flags_nxt = flags_r & ~reg_wdata[5:0];
        end
        if (reg_rd && reg_addr == `ADDR_DATA) begin
            flags_nxt[`FLG_FULL] = 1'b0;
        end
        if (idle_wake) begin
            ctrl_nxt[`CTRL_STANDBY] = 1'b0;
        end else if (quiet_hit_c && !standby) begin
            flags_nxt[`FLG_QUIET] = 1'b1;
        end
        if (done_c) begin
            if (standby) begin
                if (ctrl_r[`CTRL_EXIT_SEL] && shift_r[8]) begin
                    ctrl_nxt[`CTRL_STANDBY] = 1'b0;
                    flags_nxt[`FLG_FULL] = 1'b1;
                    data_buf_nxt = char9 ? shift_r : {1'b0, shift_r[8:1]};
                end
            end else if (flags_r[`FLG_FULL]) begin
                flags_nxt[`FLG_OVR] = 1'b1;
            end else begin
                flags_nxt[`FLG_FULL] = 1'b1;
                data_buf_nxt = char9 ? shift_r : {1'b0, shift_r[8:1]};
                flags_nxt[`FLG_FRAME] = !maj_c;
                flags_nxt[`FLG_NOISE] = flags_r[`FLG_NOISE] | noise_r | dis_c;
                flags_nxt[`FLG_PAR] = flags_r[`FLG_PAR] | parity_bad;
            end
        end
        // A software write to control lands last, so re-arming standby always takes
        if (reg_wr && reg_addr == `ADDR_CTRL) begin
            ctrl_nxt = reg_wdata[5:0];
        end
        if (reg_wr && reg_addr == `ADDR_IRQ_EN) begin
            irq_en_nxt = reg_wdata[5:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL: rdata_nxt = {10'h000, ctrl_r};
                `ADDR_IRQ_EN: rdata_nxt = {10'h000, irq_en_r};
                `ADDR_STATUS: rdata_nxt = {9'h000, state_r != st_hunt, flags_r};
                `ADDR_DATA: rdata_nxt = {7'h00, data_buf_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
        rx_irq_nxt = !ctrl_nxt[`CTRL_STANDBY] &&
            ((flags_nxt[`FLG_FULL] && irq_en_nxt[`FLG_FULL]) || (flags_nxt[`FLG_QUIET] && irq_en_nxt[`FLG_QUIET]));
        err_irq_nxt = |(flags_nxt[5:2] & irq_en_nxt[5:2]);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RESET;
            irq_en_r <= `IRQ_EN_RESET;
            flags_r <= `FLAGS_RESET;
            data_buf_r <= 9'h000;
            rdata_r <= 16'h0000;
            rx_irq_r <= 1'b0;
            err_irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            irq_en_r <= irq_en_nxt;
            flags_r <= flags_nxt;
            data_buf_r <= data_buf_nxt;
            rdata_r <= rdata_nxt;
            rx_irq_r <= rx_irq_nxt;
            err_irq_r <= err_irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign rx_irq = rx_irq_r;
    assign err_irq = err_irq_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_fe_with_full;
        $rose(flags_r[`FLG_FRAME]) |-> $rose(flags_r[`FLG_FULL]);
    endproperty
    a_fe_with_full: assert property (p_fe_with_full) else $error("framing flag rose without full");

    property p_stop_frame;
        (done_c && !standby && !flags_r[`FLG_FULL] && !maj_c) |=> flags_r[`FLG_FRAME] && flags_r[`FLG_FULL];
    endproperty
    a_stop_frame: assert property (p_stop_frame) else $error("stop majority zero gave no framing error");

    property p_stop_noise;
        (done_c && !standby && !flags_r[`FLG_FULL] && dis_c) |=> flags_r[`FLG_NOISE];
    endproperty
    a_stop_noise: assert property (p_stop_noise) else $error("stop disagreement gave no noise");

    property p_standby_quiet;
        ctrl_r[`CTRL_STANDBY] |-> !rx_irq;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("receiver irq during standby");

    property p_addr_wake;
        (done_c && standby && ctrl_r[`CTRL_EXIT_SEL] && shift_r[8] && !(reg_wr && reg_addr == `ADDR_CTRL))
            |=> !ctrl_r[`CTRL_STANDBY] && flags_r[`FLG_FULL];
    endproperty
    a_addr_wake: assert property (p_addr_wake) else $error("address mark did not wake");

    property p_overrun_keep;
        (done_c && !standby && flags_r[`FLG_FULL]) |=> flags_r[`FLG_OVR] && $stable(data_buf_r);
    endproperty
    a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost old data or flag");

    property p_frame_irq;
        (flags_r[`FLG_FRAME] && irq_en_r[`FLG_FRAME]) |-> err_irq;
    endproperty
    a_frame_irq: assert property (p_frame_irq) else $error("framing error irq missing");

    property p_stop_ends;
        (state_r == st_stop && tick && rt_r == `RT_SMP_C) |=> state_r == st_hunt ##0 rt_r == `RT_FIRST;
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop sampling did not end at tick 10");

    property p_idle_wake_silent;
        (idle_wake && !done_c) |=> !$rose(flags_r[`FLG_QUIET]) && !$rose(flags_r[`FLG_FULL]);
    endproperty
    a_idle_wake_silent: assert property (p_idle_wake_silent) else $error("waking idle set a flag");
endmodule

// File: tb/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [11:0] frame,
    input wire logic [3:0] nbits,
    input wire logic [7:0] bit_clks,
    input wire logic [3:0] glitch_bit,
    output logic txd,
    output logic busy
);
    // Frame is sent bit 0 first; the line rests high between frames
    initial begin
        txd = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                for (int b = 0; b < nbits; b++) begin
                    for (int c = 0; c < bit_clks; c++) begin
                        // Two-clock pulse near mid-bit spoils one of the three samples
                        txd <= (b == glitch_bit && (c == 17 || c == 18)) ? ~frame[b] : frame[b];
                        @(posedge ref_clk);
                    end
                end
                txd <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic ref_clk;
    logic rst;
    logic pin;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic rx_irq;
    logic err_irq;
    logic go;
    logic [11:0] frame;
    logic [3:0] nbits;
    logic [7:0] bit_clks;
    logic [3:0] glitch_bit;
    logic busy;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    // Short tick divider keeps a bit at 32 clocks
    sci_receiver #(.TICK_DIV(16'h0002)) dut (.ref_clk(ref_clk), .rst(rst), .serial_input_pin(pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_irq(rx_irq), .err_irq(err_irq));
    serial_tx_model far_end (.ref_clk(ref_clk), .go(go), .frame(frame), .nbits(nbits),
        .bit_clks(bit_clks), .glitch_bit(glitch_bit), .txd(pin), .busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            results();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic expect_reg(input string name, input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(name, reg_rdata, e);
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Start bit, data LSB first, stop level as given, then idle
    task automatic send(input logic [8:0] d, input logic nine, input logic stop, input logic [7:0] bc,
        input logic [3:0] g);
        int i;
        @(posedge ref_clk);
        frame <= nine ? {1'b1, stop, d, 1'b0} : {2'b11, stop, d[7:0], 1'b0};
        nbits <= nine ? 4'hB : 4'hA;
        bit_clks <= bc;
        glitch_bit <= g;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        #1;
        for (i = 0; i < 2000 && busy === 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        repeat (24) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        logic [7:0] d8;
        logic [3:0] gl [3];
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        go = 1'b0;
        frame = 12'hFFF;
        nbits = 4'hA;
        bit_clks = 8'h20;
        glitch_bit = 4'hF;
        gl = '{4'h0, 4'h4, 4'h9};
        d8 = $urandom(67698);
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        for (int a = 0; a < 4; a++) begin
            expect_reg("reset", 4'(a), 16'h0000);
        end
        expect_reg("unmapped", 4'hF, 16'h0000);
        $display("test reset done");

        // Off-rate characters only survive if falling edges realign the tick count
        wr(4'h1, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            d8 = $urandom;
            // A one then a zero by the third bit keeps slow frames inside the realign window
            d8[2:1] = 2'b01;
            d8[7:6] = 2'b01;
            send({1'b0, d8}, 1'b0, 1'b1, (i % 2) ? 8'h1E : 8'h22, 4'hF);
            expect_reg("status", 4'h2, 16'h0001);
            check("rx_irq", 16'(rx_irq), 16'h0001);
            expect_reg("data", 4'h3, {8'h00, d8});
            settle();
            check("rx_irq", 16'(rx_irq), 16'h0000);
        end
        $display("test drift done");

        wr(4'h1, 16'h0010);
        send(9'h000, 1'b0, 1'b0, 8'h20, 4'hF);
        expect_reg("break", 4'h2, 16'h0011);
        check("err_irq", 16'(err_irq), 16'h0001);
        check("rx_irq", 16'(rx_irq), 16'h0000);
        expect_reg("data", 4'h3, 16'h0000);
        wr(4'h2, 16'h003F);
        settle();
        check("err_irq", 16'(err_irq), 16'h0000);
        $display("test break done");

        wr(4'h1, 16'h0008);
        for (int i = 0; i < 3; i++) begin
            send(9'h05A, 1'b0, 1'b1, 8'h20, gl[i]);
            expect_reg("noise", 4'h2, 16'h0009);
            check("err_irq", 16'(err_irq), 16'h0001);
            expect_reg("data", 4'h3, 16'h005A);
            wr(4'h2, 16'h003F);
        end
        $display("test noise done");

        wr(4'h1, 16'h0004);
        send(9'h011, 1'b0, 1'b1, 8'h20, 4'hF);
        send(9'h022, 1'b0, 1'b1, 8'h20, 4'hF);
        expect_reg("overrun", 4'h2, 16'h0005);
        check("err_irq", 16'(err_irq), 16'h0001);
        expect_reg("data", 4'h3, 16'h0011);
        wr(4'h2, 16'h003F);
        $display("test overrun done");

        wr(4'h0, 16'h0018);
        wr(4'h1, 16'h0020);
        send(9'h103, 1'b1, 1'b1, 8'h20, 4'hF);
        expect_reg("parity", 4'h2, 16'h0021);
        check("err_irq", 16'(err_irq), 16'h0001);
        expect_reg("data", 4'h3, 16'h0103);
        wr(4'h2, 16'h003F);
        send(9'h101, 1'b1, 1'b1, 8'h20, 4'hF);
        expect_reg("parity ok", 4'h2, 16'h0001);
        expect_reg("data", 4'h3, 16'h0101);
        // Odd parity on 8-bit characters, where the top data bit carries the parity
        wr(4'h0, 16'h0030);
        send(9'h007, 1'b0, 1'b1, 8'h20, 4'hF);
        expect_reg("odd ok", 4'h2, 16'h0001);
        expect_reg("data", 4'h3, 16'h0007);
        send(9'h006, 1'b0, 1'b1, 8'h20, 4'hF);
        expect_reg("odd bad", 4'h2, 16'h0021);
        expect_reg("data", 4'h3, 16'h0006);
        wr(4'h2, 16'h003F);
        $display("test parity done");

        // Count from start bit flags soon after stop; count from stop needs ten more bits
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0002);
        send(9'h0FF, 1'b0, 1'b1, 8'h20, 4'hF);
        repeat (40) @(posedge ref_clk);
        expect_reg("quiet sel0", 4'h2, 16'h0003);
        check("rx_irq", 16'(rx_irq), 16'h0001);
        expect_reg("data", 4'h3, 16'h00FF);
        wr(4'h2, 16'h003F);
        wr(4'h0, 16'h0004);
        send(9'h0FF, 1'b0, 1'b1, 8'h20, 4'hF);
        repeat (40) @(posedge ref_clk);
        expect_reg("quiet sel1", 4'h2, 16'h0001);
        expect_reg("data", 4'h3, 16'h00FF);
        repeat (320) @(posedge ref_clk);
        expect_reg("quiet late", 4'h2, 16'h0002);
        wr(4'h2, 16'h003F);
        $display("test quiet done");

        wr(4'h0, 16'h000B);
        wr(4'h1, 16'h0001);
        send(9'h055, 1'b1, 1'b1, 8'h20, 4'hF);
        expect_reg("asleep", 4'h2, 16'h0000);
        expect_reg("ctrl", 4'h0, 16'h000B);
        send(9'h1A5, 1'b1, 1'b1, 8'h20, 4'hF);
        expect_reg("woken", 4'h0, 16'h000A);
        expect_reg("status", 4'h2, 16'h0001);
        check("rx_irq", 16'(rx_irq), 16'h0001);
        wr(4'h0, 16'h000B);
        settle();
        check("rx_irq", 16'(rx_irq), 16'h0000);
        expect_reg("data", 4'h3, 16'h01A5);
        $display("test address done");

        // Line already idle, so an immediate wake is an accepted outcome
        wr(4'h2, 16'h003F);
        wr(4'h0, 16'h0001);
        repeat (400) @(posedge ref_clk);
        expect_reg("idle wake", 4'h0, 16'h0000);
        expect_reg("no flags", 4'h2, 16'h0000);
        $display("test idle done");
        results();
    end
endmodule
